// ### hw/energy_accumulate_pulse_out.sv
// Operation
// - Positive overflow wraps to most negative value.
// - Negative underflow wraps to largest positive value.
// - Interrupt low on half-full or wrap, if enabled.
// - Add one sample every four clocks.
// - Add signed 12-bit offset before accumulation.
// - Sixteen offset units equal one sample unit.
// - Separate 24-bit pulse accumulator runs in parallel.
// - Pulse event on accumulator MSB rising edge.
// - Output rate is events over divider plus one.
// - Divider setting resets to 3F hex.
// - Calibration mode while mode bit set.
// - Calibration accumulates over programmed half-cycle count.
// - Voltage zero crossings mark half-cycle boundaries.
// - Period end sets sag flag, sag output low.
// - Sag enable also drives interrupt low.
// - New period starts immediately while mode set.
// - Samples add signed; negative power subtracts.
// - Energy accumulator is 40-bit two's complement.
`timescale 1ns/1ps
`default_nettype none

module energy_accumulate_pulse_out #(
    parameter int PWR_W = energy_pkg::POWER_W
) (
    // Clock and reset.
    input  wire logic                                     clock,
    input  wire logic                                     rst_n,
    // Filtered active power and line timing.
    input  wire logic signed [PWR_W-1:0]                  power_sample,
    input  wire logic                                     zero_cross_output,
    // Mode and calibration settings.
    input  wire logic                                     calibration_mode_bit,
    input  wire logic [energy_pkg::HALF_CYCLE_W-1:0]      half_cycle_count,
    // Event enables and clears.
    input  wire energy_pkg::status_t                      irq_enable,
    input  wire energy_pkg::status_t                      status_clear,
    // Setting writes.
    input  wire logic                                     offset_wr,
    input  wire logic                                     divider_wr,
    input  wire logic [energy_pkg::OFFSET_W-1:0]          reg_wdata,
    // Setting read-back.
    output logic [energy_pkg::OFFSET_W-1:0]               power_offset_trim,
    output logic [energy_pkg::DIVIDER_W-1:0]              pulse_rate_divider,
    // Energy results and status.
    output logic signed [energy_pkg::ENERGY_W-1:0]        energy_accumulator,
    output logic signed [energy_pkg::ENERGY_W-1:0]        cal_energy_result,
    output energy_pkg::status_t                           status,
    output logic                                          irq_n,
    output logic                                          sag_n,
    // Calibration pulse.
    output logic                                          calibration_pulse_out
);
    import energy_pkg::*;

    // Both accumulators carry the offset's four fractional bits below the visible value.
    localparam int EW    = ENERGY_W + OFFSET_FRAC;
    localparam int PW    = PULSE_ACC_W + OFFSET_FRAC;
    localparam int AW    = PWR_W + OFFSET_FRAC + 1;
    localparam int PH_W  = $clog2(SAMPLE_PERIOD);

    if (AW > PW || PWR_W < OFFSET_W - OFFSET_FRAC) begin : g_bad_power
        $error("power sample width does not fit the accumulators");
    end

    logic [PH_W-1:0]      phase;
    logic                 sample_tick;
    logic signed [AW-1:0] addend;
    logic signed [EW-1:0] energy_full;
    logic signed [EW-1:0] energy_base;
    logic signed [EW-1:0] next_energy;
    logic signed [PW-1:0] pulse_acc;
    logic signed [PW-1:0] next_pulse;
    logic                 add_now;
    logic                 msb_rise;
    logic                 wrap_event;
    logic                 half_event;
    logic                 cal_start;
    logic                 cal_end;
    logic                 cal_running;
    status_t              events;

    // Sample cadence: one accumulation slot per four master clocks.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    assign sample_tick = phase == PH_W'(SAMPLE_PERIOD - 1);

    // Settings written by software.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            power_offset_trim <= OFFSET_RESET;
        end else if (offset_wr) begin
            power_offset_trim <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_rate_divider <= DIVIDER_RESET;
        end else if (divider_wr) begin
            pulse_rate_divider <= reg_wdata;
        end
    end

    // The sample is shifted up by the fractional bits so one offset unit is 1/16 sample.
    assign addend = AW'(signed'({power_sample, {OFFSET_FRAC{1'b0}}}))
                  + AW'(signed'(power_offset_trim));

    // Outside calibration the energy integrates continuously; inside it, only during a period.
    assign add_now = sample_tick && (!calibration_mode_bit || cal_running || cal_start);

    assign energy_base = cal_start ? '0 : energy_full;
    // Plain two's-complement addition wraps at both ends of the range.
    assign next_energy = energy_base + (add_now ? EW'(addend) : '0);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            energy_full <= '0;
        end else begin
            energy_full <= next_energy;
        end
    end

    assign energy_accumulator = energy_full[EW-1:OFFSET_FRAC];

    // Sign flips under an addend of the old sign are wraps; a sign/next-bit split is half scale.
    assign wrap_event = add_now && (energy_base[EW-1] == addend[AW-1])
                      && (next_energy[EW-1] != energy_base[EW-1]);
    assign half_event = add_now && !wrap_event && (next_energy[EW-1] ^ next_energy[EW-2])
                      && !(energy_base[EW-1] ^ energy_base[EW-2]);

    // The period's result is caught before the restart clears the accumulator.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_energy_result <= '0;
        end else if (cal_end) begin
            cal_energy_result <= energy_full[EW-1:OFFSET_FRAC];
        end
    end

    // Pulse accumulator runs on every slot, independent of calibration gating.
    assign next_pulse = pulse_acc + PW'(addend);
    assign msb_rise   = sample_tick && !pulse_acc[PW-1] && next_pulse[PW-1];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_acc <= '0;
        end else if (sample_tick) begin
            pulse_acc <= next_pulse;
        end
    end

    pulse_divider #(
        .DIV_W   (DIVIDER_W),
        .WIDTH_C (PULSE_WIDTH_CYCLES)
    ) u_divider (
        .clock     (clock),
        .rst_n     (rst_n),
        .msb_event (msb_rise),
        .divide_by (pulse_rate_divider),
        .pulse_out (calibration_pulse_out)
    );

    cal_period #(
        .HC_W (HALF_CYCLE_W)
    ) u_cal (
        .clock        (clock),
        .rst_n        (rst_n),
        .enable       (calibration_mode_bit),
        .zero_cross   (zero_cross_output),
        .half_cycles  (half_cycle_count),
        .period_start (cal_start),
        .period_end   (cal_end),
        .running      (cal_running)
    );

    // Sticky flags: a new event beats a clear in the same cycle.
    assign events = '{sag: cal_end, wrap: wrap_event, half: half_event};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status <= STATUS_RESET;
        end else begin
            status <= (status & ~status_clear) | events;
        end
    end

    assign irq_n = ~|(status & irq_enable);
    assign sag_n = ~status.sag;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_tick_period: assert property (sample_tick |=> !sample_tick [*3] ##1 sample_tick)
        else $error("accumulation slots are not four clocks apart");
    a_wrap_positive: assert property (add_now && !cal_start && energy_full[EW-1] == 1'b0 && addend > 0
            && next_energy[EW-1] |=> status.wrap && energy_accumulator < 0)
        else $error("positive overflow did not wrap negative");
    a_wrap_negative: assert property (add_now && !cal_start && energy_full[EW-1] && addend < 0
            && !next_energy[EW-1] |=> status.wrap && energy_accumulator > 0)
        else $error("negative underflow did not wrap positive");
    a_half_irq: assert property (half_event && irq_enable.half && !status_clear.half |=> !irq_n)
        else $error("half-scale event did not assert interrupt");
    a_signed_add: assert property (add_now && !cal_start
            |=> energy_full == $past(energy_full) + EW'($past(addend)))
        else $error("energy did not take the signed sample");
    a_offset_scale: assert property (add_now && !cal_start && power_sample == '0
            && power_offset_trim == 12'h010 |=> energy_accumulator == $past(energy_accumulator) + 40'sh1)
        else $error("sixteen offset units did not equal one sample unit");
    a_pulse_acc: assert property (sample_tick |=> pulse_acc == $past(pulse_acc) + PW'($past(addend)))
        else $error("pulse accumulator missed a slot");
    a_msb_edge: assert property ($rose(pulse_acc[PW-1]) |-> $past(msb_rise))
        else $error("msb rising without a pulse event");
    a_divider_reset: assert property ($rose(rst_n) |-> pulse_rate_divider == DIVIDER_RESET)
        else $error("divider setting not at reset value");
    a_cal_gate: assert property (calibration_mode_bit && !cal_running && !cal_start
            |=> energy_full == $past(energy_full))
        else $error("energy moved outside a calibration period");
    a_cal_clear: assert property (cal_start && !sample_tick |=> energy_full == '0)
        else $error("calibration period did not start from zero");
    a_cal_end_sag: assert property (cal_end |=> status.sag && !sag_n)
        else $error("period end did not raise sag");
    a_sag_irq: assert property (cal_end && irq_enable.sag && !status_clear.sag |=> !irq_n)
        else $error("period end did not assert interrupt");

    c_wrap: cover property (wrap_event);
    c_cal_end: cover property (calibration_mode_bit && cal_end);
    c_pulse: cover property ($rose(calibration_pulse_out));

endmodule

`default_nettype wire

// ### hw/energy_pkg.sv
package energy_pkg;

    // Datapath widths.
    localparam int ENERGY_W      = 40;
    localparam int PULSE_ACC_W   = 24;
    localparam int OFFSET_W      = 12;
    localparam int OFFSET_FRAC   = 4;
    localparam int DIVIDER_W     = 12;
    localparam int HALF_CYCLE_W  = 8;
    localparam int POWER_W       = 16;

    // Accumulation cadence in master clock periods.
    localparam int SAMPLE_PERIOD = 4;

    // Width of each calibration pulse in master clock periods.
    localparam int PULSE_WIDTH_CYCLES = 8;

    // Reset values of the software-written settings.
    localparam logic [DIVIDER_W-1:0] DIVIDER_RESET = 12'h03F;
    localparam logic [OFFSET_W-1:0]  OFFSET_RESET  = 12'h000;

    // Sticky event flags; one field each for status, enable and clear.
    typedef struct packed {
        logic sag;
        logic wrap;
        logic half;
    } status_t;

    localparam status_t STATUS_RESET = 3'h0;

endpackage

// ### hw/pulse_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_divider #(
    parameter int DIV_W   = energy_pkg::DIVIDER_W,
    parameter int WIDTH_C = energy_pkg::PULSE_WIDTH_CYCLES
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Undivided events and divide setting.
    input  wire logic             msb_event,
    input  wire logic [DIV_W-1:0] divide_by,
    // Divided pulse.
    output logic                  pulse_out
);
    import energy_pkg::*;

    localparam int WC_W = $clog2(WIDTH_C + 1);

    if (WIDTH_C < 1) begin : g_bad_width
        $error("pulse width must be at least one cycle");
    end

    logic [DIV_W-1:0] event_count;
    logic [WC_W-1:0]  width_left;
    logic             fire;

    assign fire = msb_event && (event_count >= divide_by);

    // Every (divide_by + 1)th event fires one output pulse.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            event_count <= '0;
        end else if (msb_event) begin
            event_count <= fire ? '0 : event_count + 1'b1;
        end
    end

    // A new fire during a pulse restarts its width, so the two pulses merge into one longer pulse.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            width_left <= '0;
            pulse_out  <= 1'b0;
        end else if (fire) begin
            width_left <= WC_W'(WIDTH_C - 1);
            pulse_out  <= 1'b1;
        end else if (width_left != '0) begin
            width_left <= width_left - 1'b1;
        end else begin
            pulse_out <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_divide_fire: assert property (msb_event && event_count == divide_by |=> pulse_out && event_count == '0)
        else $error("divider did not fire on the last event");
    a_pulse_width: assert property ($rose(pulse_out) && WIDTH_C == 8 |-> pulse_out[*8])
        else $error("calibration pulse shorter than its width");
    c_divided_pulse: cover property ($rose(pulse_out) && divide_by != '0);

endmodule

`default_nettype wire

// ### hw/cal_period.sv
`timescale 1ns/1ps
`default_nettype none

module cal_period #(
    parameter int HC_W = energy_pkg::HALF_CYCLE_W
) (
    // Clock and reset.
    input  wire logic            clock,
    input  wire logic            rst_n,
    // Mode and line timing.
    input  wire logic            enable,
    input  wire logic            zero_cross,
    input  wire logic [HC_W-1:0] half_cycles,
    // Period events.
    output logic                 period_start,
    output logic                 period_end,
    output logic                 running
);
    import energy_pkg::*;

    typedef enum logic [2:0] {
        IDLE = 3'b001,
        WAIT = 3'b010,
        RUN  = 3'b100
    } cal_state_t;

    cal_state_t      state;
    logic            zx_prev;
    logic            crossing;
    logic [HC_W-1:0] crossed;
    logic            last_half;

    // Both edges of the voltage sign mark a half-cycle boundary.
    assign crossing  = zero_cross != zx_prev;
    // A count of zero behaves as one, so the period still ends.
    assign last_half = (HC_W+1)'(crossed) + 1'b1 >= (HC_W+1)'(half_cycles);
    assign running   = state == RUN;

    // The previous level follows the pin even in reset, so a pin idling high gives no false crossing after reset.
    always_ff @(posedge clock) begin
        zx_prev <= zero_cross;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state        <= IDLE;
            crossed      <= '0;
            period_start <= 1'b0;
            period_end   <= 1'b0;
        end else begin
            period_start <= 1'b0;
            period_end   <= 1'b0;
            case (state)
                IDLE: begin
                    if (enable) begin
                        state <= WAIT;
                    end
                end
                WAIT: begin
                    if (!enable) begin
                        state <= IDLE;
                    end else if (crossing) begin
                        state        <= RUN;
                        crossed      <= '0;
                        period_start <= 1'b1;
                    end
                end
                RUN: begin
                    if (!enable) begin
                        state <= IDLE;
                    end else if (crossing && last_half) begin
                        crossed      <= '0;
                        period_end   <= 1'b1;
                        period_start <= 1'b1;
                    end else if (crossing) begin
                        crossed <= crossed + 1'b1;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_restart_period: assert property (period_end && enable |-> period_start ##1 running)
        else $error("new calibration period did not start");
    a_zx_start: assert property (state == WAIT && enable && crossing |=> period_start)
        else $error("zero crossing did not open a period");
    a_one_half: assert property (running && half_cycles == 1 && crossing && enable |=> period_end)
        else $error("single half-cycle period did not end");
    c_two_periods: cover property (period_end ##[1:1000] period_end);

endmodule

`default_nettype wire

// ### tb/pulse_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Counting equipment on the calibration pulse line.
// It counts pulses, times the spacing between rising edges and times the width of each pulse.
module pulse_counter (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst_n,
    // Pulse line.
    input  wire logic pulse_in,
    // Measurements.
    output var int    pulse_count,
    output var int    last_interval,
    output var int    last_width
);
    int   since_rise;
    int   high_len;
    logic prev;

    always @(posedge clock) begin
        if (!rst_n) begin
            pulse_count   <= 0;
            last_interval <= 0;
            last_width    <= 0;
            since_rise    <= 0;
            high_len      <= 0;
            prev          <= 1'b0;
        end else begin
            prev       <= pulse_in;
            since_rise <= since_rise + 1;
            if (pulse_in && !prev) begin
                pulse_count   <= pulse_count + 1;
                last_interval <= since_rise;
                since_rise    <= 1;
            end
            if (pulse_in) begin
                high_len <= high_len + 1;
            end else if (prev) begin
                last_width <= high_len;
                high_len   <= 0;
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import energy_pkg::*;

    logic                       clock                = 1'b0;
    logic                       rst_n                = 1'b0;
    logic signed [POWER_W-1:0]  power_sample         = '0;
    logic                       zero_cross_output    = 1'b0;
    logic                       calibration_mode_bit = 1'b0;
    logic [HALF_CYCLE_W-1:0]    half_cycle_count     = 8'h02;
    status_t                    irq_enable           = 3'h0;
    status_t                    status_clear         = 3'h0;
    logic                       offset_wr            = 1'b0;
    logic                       divider_wr           = 1'b0;
    logic [OFFSET_W-1:0]        reg_wdata            = 12'h000;
    logic [OFFSET_W-1:0]        power_offset_trim;
    logic [DIVIDER_W-1:0]       pulse_rate_divider;
    logic signed [ENERGY_W-1:0] energy_accumulator;
    logic signed [ENERGY_W-1:0] cal_energy_result;
    status_t                    status;
    logic                       irq_n;
    logic                       sag_n;
    logic                       calibration_pulse_out;
    int                         pulse_count;
    int                         last_interval;
    int                         last_width;
    int                         cyc                  = 0;
    int                         tz[$];
    int                         err_count            = 0;
    int                         total_checks         = 0;

    always #25 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    energy_accumulate_pulse_out #(.PWR_W(POWER_W)) u_energy_accumulate_pulse_out (
        .clock(clock), .rst_n(rst_n), .power_sample(power_sample),
        .zero_cross_output(zero_cross_output), .calibration_mode_bit(calibration_mode_bit),
        .half_cycle_count(half_cycle_count), .irq_enable(irq_enable), .status_clear(status_clear),
        .offset_wr(offset_wr), .divider_wr(divider_wr), .reg_wdata(reg_wdata),
        .power_offset_trim(power_offset_trim), .pulse_rate_divider(pulse_rate_divider),
        .energy_accumulator(energy_accumulator), .cal_energy_result(cal_energy_result),
        .status(status), .irq_n(irq_n), .sag_n(sag_n), .calibration_pulse_out(calibration_pulse_out)
    );

    pulse_counter u_pulse_counter (
        .clock(clock), .rst_n(rst_n), .pulse_in(calibration_pulse_out),
        .pulse_count(pulse_count), .last_interval(last_interval), .last_width(last_width)
    );

    task automatic complete_run;
        $display("checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic write_reg(input logic to_div, input logic [OFFSET_W-1:0] d);
        @(posedge clock);
        divider_wr <= to_div;
        offset_wr  <= ~to_div;
        reg_wdata  <= d;
        @(posedge clock);
        divider_wr <= 1'b0;
        offset_wr  <= 1'b0;
    endtask

    task automatic t_reset;
        @(negedge clock);
        chk(pulse_rate_divider === DIVIDER_RESET, "divider reset value");
        chk(power_offset_trim === OFFSET_RESET && status === STATUS_RESET, "offset or status reset value");
        chk(energy_accumulator === 40'sh0 && irq_n === 1'b1 && sag_n === 1'b1, "energy or outputs at reset");
        write_reg(1'b1, 12'hABC);
        write_reg(1'b0, 12'h7FF);
        @(negedge clock);
        chk(pulse_rate_divider === 12'hABC && power_offset_trim === 12'h7FF, "setting read-back");
    endtask

    // A window of a whole number of four-cycle slots makes the step exact whatever the phase.
    task automatic t_accum(input logic signed [POWER_W-1:0] s, input logic [OFFSET_W-1:0] o,
                           input int n, input logic signed [ENERGY_W-1:0] d);
        logic signed [ENERGY_W-1:0] e0;
        write_reg(1'b0, o);
        power_sample <= s;
        repeat (8) @(posedge clock);
        @(negedge clock);
        e0 = energy_accumulator;
        repeat (n) @(negedge clock);
        chk(energy_accumulator - e0 === d, "energy step");
    endtask

    task automatic wait_pulse;
        int c;
        c = pulse_count;
        for (int i = 0; i < 30000 && pulse_count == c; i++) @(posedge clock);
        chk(pulse_count != c, "no calibration pulse");
    endtask

    // At full positive power the 24-bit total wraps every 512 or 513 slots.
    task automatic t_pulse(input logic [DIVIDER_W-1:0] div);
        int lo;
        int hi;
        lo = (int'(div) + 1) * 2048;
        hi = (int'(div) + 1) * 2052;
        write_reg(1'b0, 12'h000);
        write_reg(1'b1, div);
        power_sample <= 16'sh7FFF;
        wait_pulse();
        wait_pulse();
        @(negedge clock);
        chk(last_interval >= lo && last_interval <= hi, "pulse spacing");
        chk(last_width == PULSE_WIDTH_CYCLES, "pulse width");
    endtask

    task automatic toggle_zx(input int n);
        repeat (n) begin
            repeat (40) @(posedge clock);
            zero_cross_output <= ~zero_cross_output;
            tz.push_back(cyc);
        end
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic clear_status;
        @(posedge clock);
        status_clear <= 3'h7;
        @(posedge clock);
        status_clear <= 3'h0;
        @(negedge clock);
    endtask

    task automatic t_cal;
        logic signed [ENERGY_W-1:0] e0;
        int                         slots;
        write_reg(1'b0, 12'h000);
        power_sample         <= 16'sh0001;
        irq_enable           <= 3'h4;
        calibration_mode_bit <= 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        e0 = energy_accumulator;
        repeat (40) @(negedge clock);
        chk(energy_accumulator === e0, "slots outside a period must not add");
        toggle_zx(3);
        chk(sag_n === 1'b0 && status.sag === 1'b1 && irq_n === 1'b0, "first period end");
        chk(energy_accumulator >= 40'sh0 && energy_accumulator < 40'sh3, "energy cleared");
        clear_status();
        chk(sag_n === 1'b1 && irq_n === 1'b1, "flags cleared");
        // The first result is thrown away; the second covers a known span.
        toggle_zx(2);
        slots = (tz[4] - tz[2]) / 4;
        chk(cal_energy_result >= slots - 1 && cal_energy_result <= slots + 1, "period result");
        chk(sag_n === 1'b0 && irq_n === 1'b0, "second period end");
        @(posedge clock);
        irq_enable       <= 3'h0;
        half_cycle_count <= 8'h01;
        clear_status();
        toggle_zx(2);
        chk(sag_n === 1'b0 && irq_n === 1'b1, "sag without interrupt enable");
        slots = (tz[6] - tz[5]) / 4;
        chk(cal_energy_result >= slots - 1 && cal_energy_result <= slots + 1, "one half-cycle period");
        @(posedge clock);
        calibration_mode_bit <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_accum(16'sh0005, 12'h000, 4, 40'sh5);
        t_accum(16'sh0005, 12'h000, 64, 40'sh50);
        t_accum(-16'sh0003, 12'h000, 64, -40'sh30);
        t_accum(16'sh0000, 12'h010, 64, 40'sh10);
        t_accum(16'sh0000, 12'hFF0, 64, -40'sh10);
        t_accum(16'sh0002, 12'h008, 64, 40'sh28);
        t_pulse(12'h000);
        t_pulse(12'h002);
        t_cal();
        complete_run();
    end

    // Whole run needs about 16000 cycles; this leaves ample margin.
    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule

`default_nettype wire
